// *** logic/dram_strobe_timing_config.sv ***
// dram strobe sequencer with its programmable timing register on wishbone
//
// What this block does
// - RAS stays asserted at least 4, 5, 6 or 7 cycles for codes 0..3 of bits 12:11, reset 6.
// - Column address is held 1 or 2 cycles after CAS asserts per bit 10, reset 2.
// - CAS is asserted 2, 3, 4 or 5 cycles on reads per bits 9:8, reset 3.
// - CAS is asserted 2, 3, 4 or 5 cycles on writes per bits 7:6, reset 2.
// - CAS stays deasserted 1 or 2 cycles between assertions per bit 5, reset 1.
// - Column address is driven 1 or 2 cycles after RAS asserts per bit 4, reset 2.
// - Bits 3:2 set the cycles from RAS assertion to CAS assertion.
`timescale 1ns/1ps
`include "dram_timing_consts.svh"

module dram_strobe_timing_config
  import dram_timing_pkg::*;
#(
  parameter int             AddrWidth    = 12,
  parameter logic [3:0]     RowPrecharge = 4'h3
)
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [3:0]           wbAdr,
  input  wire logic [31:0]          wbDatW,
  input  wire logic [3:0]           wbSel,
  input  wire logic                 wbWe,
  input  wire logic                 wbCyc,
  input  wire logic                 wbStb,
  output logic                      wbAck,
  output logic      [31:0]          wbDatR,
  input  wire logic                 reqValid,
  input  wire logic                 reqWrite,
  input  wire logic [AddrWidth-1:0] reqRow,
  input  wire logic [AddrWidth-1:0] reqCol,
  input  wire logic [1:0]           reqBeats,
  output logic                      reqReady,
  output logic                      accessDone,
  output logic                      rasN,
  output logic                      casN,
  output logic                      weN,
  output logic      [AddrWidth-1:0] dramAddr
);

  typedef struct packed {
    seq_state_t           st;
    logic [15:0]          timing;
    logic [15:0]          snap;
    logic [7:0]           accesses;
    logic                 wbAck;
    logic [31:0]          wbDatR;
    logic                 reqReady;
    logic                 accessDone;
    logic                 rasN;
    logic                 casN;
    logic                 weN;
    logic                 write;
    logic [AddrWidth-1:0] addr;
    logic [AddrWidth-1:0] col;
    logic [1:0]           beatsLeft;
    logic [5:0]           tRas;
    logic [3:0]           casAge;
    logic [3:0]           cnt;
  } state_t;

  state_t s;
  state_t next_s;

  logic [3:0] row_strobe_pulse_width;
  logic [3:0] colHold;
  logic [3:0] rdWidth;
  logic [3:0] wrWidth;
  logic [3:0] casPre;
  logic [3:0] colDelay;
  logic [3:0] casDelay;
  logic [3:0] casWidth;

  // decoding the snapshot, not the live register, keeps a running access stable
  dram_timing_decode u_decode
  (
    .timing   (s.snap),
    .row_strobe_pulse_width    (row_strobe_pulse_width),
    .colHold  (colHold),
    .rdWidth  (rdWidth),
    .wrWidth  (wrWidth),
    .casPre   (casPre),
    .colDelay (colDelay),
    .casDelay (casDelay)
  );

  function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [15:0] wdat,
                                             input logic [1:0] sel);
    mergeBytes = old;
    if (sel[0])
      mergeBytes[7:0] = wdat[7:0];
    if (sel[1])
      mergeBytes[15:8] = wdat[15:8];
  endfunction

  always_comb
  begin
    next_s            = s;
    next_s.wbAck      = 1'b0;
    next_s.accessDone = 1'b0;
    casWidth          = s.write ? wrWidth : rdWidth;

    // wishbone classic slave, ack one cycle after the strobe, dropped next cycle
    if (wbCyc && wbStb && !s.wbAck)
    begin
      next_s.wbAck  = 1'b1;
      next_s.wbDatR = 32'h0000_0000;
      case (wbAdr)
        `TIMING_OFS:
        begin
          next_s.wbDatR = {16'h0000, s.timing};
        end
        `STATUS_OFS:
        begin
          next_s.wbDatR[`STATUS_BUSY_BIT] = (s.st != sIdle);
          next_s.wbDatR[`STATUS_CNT_LSB+7:`STATUS_CNT_LSB] = s.accesses;
        end
        default:
        begin
          next_s.wbDatR = 32'h0000_0000;
        end
      endcase
    end

    // the write lands at the edge where the master sees ack high
    if (wbCyc && wbStb && wbWe && s.wbAck && wbAdr == `TIMING_OFS)
      next_s.timing = mergeBytes(s.timing, wbDatW[15:0], wbSel[1:0]) & `TIMING_WR_MASK;

    // tRas counts while ras is low, casAge while cas is low, cnt every cycle, all saturating so long holds never wrap
    if (!s.rasN && s.tRas != 6'h3F)
      next_s.tRas = s.tRas + 6'h01;
    if (!s.casN && s.casAge != 4'hF)
      next_s.casAge = s.casAge + 4'h1;
    if (s.cnt != 4'hF)
      next_s.cnt = s.cnt + 4'h1;

    case (s.st)
      sIdle:
      begin
        if (reqValid && s.reqReady)
        begin
          next_s.st        = sRowDelay;
          next_s.rasN      = 1'b0;
          next_s.tRas      = 6'h01;
          next_s.addr      = reqRow;
          next_s.col       = reqCol;
          next_s.beatsLeft = reqBeats;
          next_s.write     = reqWrite;
          next_s.weN       = !reqWrite;
          next_s.snap      = s.timing;
          next_s.reqReady  = 1'b0;
        end
      end
      sRowDelay:
      begin
        if (s.tRas == {2'b00, colDelay})
          next_s.addr = s.col;
        if (s.tRas == {2'b00, casDelay})
        begin
          next_s.casN   = 1'b0;
          next_s.casAge = 4'h1;
          next_s.st     = sCasOn;
        end
      end
      sCasOn:
      begin
        // next beat's column only after the hold time has passed
        if (s.beatsLeft != 2'b00 && s.casAge == colHold)
        begin
          next_s.col  = s.col + 1'b1;
          next_s.addr = s.col + 1'b1;
        end
        if (s.casAge == casWidth)
        begin
          next_s.casN   = 1'b1;
          next_s.casAge = 4'h0;
          next_s.cnt    = 4'h1;
          if (s.beatsLeft == 2'b00)
            next_s.st = sRasHold;
          else
          begin
            next_s.beatsLeft = s.beatsLeft - 2'b01;
            next_s.st        = sCasOff;
          end
        end
      end
      sCasOff:
      begin
        if (s.cnt == casPre)
        begin
          next_s.casN   = 1'b0;
          next_s.casAge = 4'h1;
          next_s.st     = sCasOn;
        end
      end
      sRasHold:
      begin
        // ras also covers the last cas pulse, even if the width is set short
        if (s.tRas >= {2'b00, row_strobe_pulse_width})
        begin
          next_s.rasN = 1'b1;
          next_s.weN  = 1'b1;
          next_s.cnt  = 4'h1;
          next_s.st   = sPrecharge;
        end
      end
      sPrecharge:
      begin
        if (s.cnt >= RowPrecharge)
        begin
          next_s.st         = sIdle;
          next_s.reqReady   = 1'b1;
          next_s.accessDone = 1'b1;
          next_s.accesses   = s.accesses + 8'h01;
        end
      end
      default:
      begin
        next_s.st = sIdle;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s          <= '0;
      s.st       <= sIdle;
      s.timing   <= `TIMING_RESET;
      s.snap     <= `TIMING_RESET;
      s.reqReady <= 1'b1;
      s.rasN     <= 1'b1;
      s.casN     <= 1'b1;
      s.weN      <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign wbAck      = s.wbAck;
  assign wbDatR     = s.wbDatR;
  assign reqReady   = s.reqReady;
  assign accessDone = s.accessDone;
  assign rasN       = s.rasN;
  assign casN       = s.casN;
  assign weN        = s.weN;
  assign dramAddr   = s.addr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_reqTaken;
    reqValid && reqReady;
  endsequence

  sequence s_casFirst;
    $fell(casN) && s.st == sCasOn && $past(s.st) == sRowDelay;
  endsequence

  sequence s_casAgain;
    $fell(casN) && $past(s.st) == sCasOff;
  endsequence

  property p_rasWidth;
    $rose(rasN) |-> $past(s.tRas) >= {2'b00, $past(row_strobe_pulse_width)};
  endproperty
  a_rasWidth: assert property (p_rasWidth) else $error("ras released early");

  property p_colHold;
    $changed(dramAddr) && !casN && s.st == sCasOn |-> $past(s.casAge) == $past(colHold);
  endproperty
  a_colHold: assert property (p_colHold) else $error("column moved off hold time");

  property p_readWidth;
    $rose(casN) && !s.write |-> $past(s.casAge) == $past(rdWidth);
  endproperty
  a_readWidth: assert property (p_readWidth) else $error("read cas width wrong");

  property p_writeWidth;
    $rose(casN) && s.write |-> $past(s.casAge) == $past(wrWidth);
  endproperty
  a_writeWidth: assert property (p_writeWidth) else $error("write cas width wrong");

  property p_casPrecharge;
    s_casAgain |-> $past(s.cnt) == $past(casPre);
  endproperty
  a_casPrecharge: assert property (p_casPrecharge) else $error("cas precharge wrong");

  property p_colAddrDelay;
    s.st == sRowDelay && s.tRas == {2'b00, colDelay} |=> dramAddr == $past(s.col);
  endproperty
  a_colAddrDelay: assert property (p_colAddrDelay) else $error("column address late");

  property p_rasToCas;
    s_casFirst |-> $past(s.tRas) == {2'b00, $past(casDelay)} && !rasN;
  endproperty
  a_rasToCas: assert property (p_rasToCas) else $error("ras to cas delay wrong");

  property p_snapshot;
    s_reqTaken |=> s.snap == $past(s.timing) && !rasN ##1 $stable(s.snap);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("timing not captured at start");

endmodule

// *** logic/dram_timing_decode.sv ***
// turns the timing register fields into cycle counts
`timescale 1ns/1ps
`include "dram_timing_consts.svh"

module dram_timing_decode
(
  input  wire logic [15:0] timing,
  output logic      [3:0]  row_strobe_pulse_width,
  output logic      [3:0]  colHold,
  output logic      [3:0]  rdWidth,
  output logic      [3:0]  wrWidth,
  output logic      [3:0]  casPre,
  output logic      [3:0]  colDelay,
  output logic      [3:0]  casDelay
);

  function automatic logic [3:0] codeToCycles(input logic [1:0] code, input logic [3:0] base);
    codeToCycles = base + {2'b00, code};
  endfunction

  logic [1:0] casDelayCode;

  always_comb
  begin
    casDelayCode = timing[`CAS_DELAY_LSB+1:`CAS_DELAY_LSB];
    row_strobe_pulse_width    = codeToCycles(timing[`RAS_WIDTH_LSB+1:`RAS_WIDTH_LSB], `RAS_WIDTH_BASE);
    colHold  = timing[`COL_HOLD_BIT] ? 4'h2 : 4'h1;
    rdWidth  = codeToCycles(timing[`RD_WIDTH_LSB+1:`RD_WIDTH_LSB], `CASW_BASE);
    wrWidth  = codeToCycles(timing[`WR_WIDTH_LSB+1:`WR_WIDTH_LSB], `CASW_BASE);
    casPre   = timing[`CAS_PRE_BIT] ? 4'h2 : 4'h1;
    colDelay = timing[`COL_DELAY_BIT] ? 4'h2 : 4'h1;
    // reserved codes fall back to the shortest legal delay
    if (casDelayCode == `CAS_DELAY_RSV0 || casDelayCode == `CAS_DELAY_RSV3)
      casDelay = `CAS_DELAY_FALLBACK;
    else
      casDelay = codeToCycles(casDelayCode, `CAS_DELAY_BASE);
  end

endmodule

// *** pkg/dram_timing_consts.svh ***
// register offsets, field positions, reset values and cycle bases of the timing block
`ifndef DRAM_TIMING_CONSTS_SVH
`define DRAM_TIMING_CONSTS_SVH

`define TIMING_OFS      4'h0
`define STATUS_OFS      4'h4

`define TIMING_RESET    16'h1514
`define TIMING_WR_MASK  16'h1FFC

`define RAS_WIDTH_LSB      11
`define COL_HOLD_BIT       10
`define RD_WIDTH_LSB       8
`define WR_WIDTH_LSB       6
`define CAS_PRE_BIT        5
`define COL_DELAY_BIT      4
`define CAS_DELAY_LSB      2

`define RAS_WIDTH_BASE     4'h4
`define CASW_BASE          4'h2
`define CAS_DELAY_BASE     4'h2
`define CAS_DELAY_FALLBACK 4'h3
`define CAS_DELAY_RSV0     2'h0
`define CAS_DELAY_RSV3     2'h3

`define STATUS_BUSY_BIT 0
`define STATUS_CNT_LSB  8

`endif

// *** pkg/dram_timing_pkg.sv ***
// types shared by the strobe timing block
package dram_timing_pkg;

  typedef enum logic [2:0] {
    sIdle,
    sRowDelay,
    sCasOn,
    sCasOff,
    sRasHold,
    sPrecharge
  } seq_state_t;

endpackage

// *** verif/dram_array_model.sv ***
// dram array stand-in that measures strobe and address timing in clk cycles
`timescale 1ns/1ps
module dram_array_model
#(
  parameter int AW = 12
)
(
  input  wire logic          clk,
  input  wire logic          rasN,
  input  wire logic          casN,
  input  wire logic          weN,
  input  wire logic [AW-1:0] dramAddr,
  output logic      [7:0]    rasW,
  output logic      [7:0]    casDelayM,
  output logic      [7:0]    colDelayM,
  output logic      [7:0]    casW,
  output logic      [7:0]    casPreM,
  output logic      [7:0]    colHoldM,
  output logic               weLow
);
  // t counts cycles since the row strobe fell; 0 in the fall cycle
  logic [7:0]    t = 8'h00;
  logic [7:0]    casFall = 8'h00;
  logic [7:0]    casRise = 8'h00;
  logic [1:0]    nChg = 2'h0;
  logic          beat = 1'b0;
  logic          rasPrev = 1'b1;
  logic          casPrev = 1'b1;
  logic [AW-1:0] lastAddr = '0;

  always_ff @(posedge clk)
  begin
    rasPrev <= rasN;
    casPrev <= casN;
    lastAddr <= dramAddr;
    t <= rasN ? 8'h00 : t + 8'h01;
    if (!rasN && rasPrev)
    begin
      nChg <= 2'h0;
      beat <= 1'b0;
    end
    // the row address lands in the fall cycle, so only later changes count
    if (!rasN && t != 8'h00 && dramAddr != lastAddr)
    begin
      nChg <= nChg + 2'h1;
      if (nChg == 2'h0)
        colDelayM <= t;
      if (nChg == 2'h1)
        colHoldM <= t - casFall;
    end
    if (!casN && casPrev)
    begin
      casFall <= t;
      if (!beat)
        casDelayM <= t;
      else
        casPreM <= t - casRise;
      beat <= 1'b1;
      weLow <= !weN;
    end
    if (casN && !casPrev)
    begin
      casRise <= t;
      casW <= t - casFall;
    end
    if (rasN && !rasPrev)
      rasW <= t;
  end
endmodule

// *** verif/test_dram_strobe_timing_config.sv ***
// self-checking bench for the dram strobe timing block
`timescale 1ns/1ps
module test_dram_strobe_timing_config;
  logic        clk, rstn, wbWe, wbCyc, wbStb, wbAck, reqValid, reqWrite;
  logic        reqReady, accessDone, rasN, casN, weN, weLow;
  logic [3:0]  wbAdr, wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic [11:0] reqRow, reqCol, dramAddr;
  logic [1:0]  reqBeats;
  logic [7:0]  rasW, casDelayM, colDelayM, casW, casPreM, colHoldM;
  logic [15:0] q;
  // last entry uses a reserved strobe delay code, which acts as the shortest delay
  logic [15:0] cfg [5] = '{16'h1514, 16'h1828, 16'h1BD4, 16'h0A54, 16'h181C};
  int          num_errors = 0;
  int          checks_done = 0;

  dram_strobe_timing_config u_dut (.clk(clk), .rstn(rstn), .wbAdr(wbAdr), .wbDatW(wbDatW),
    .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbDatR(wbDatR),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqRow(reqRow), .reqCol(reqCol),
    .reqBeats(reqBeats), .reqReady(reqReady), .accessDone(accessDone), .rasN(rasN),
    .casN(casN), .weN(weN), .dramAddr(dramAddr));

  dram_array_model u_mem (.clk(clk), .rasN(rasN), .casN(casN), .weN(weN),
    .dramAddr(dramAddr), .rasW(rasW), .casDelayM(casDelayM), .colDelayM(colDelayM),
    .casW(casW), .casPreM(casPreM), .colHoldM(colHoldM), .weLow(weLow));

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle; held until ack is sampled, then one idle cycle
  task automatic wbCycle(input logic we, input logic [3:0] adr, input logic [15:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatW <= {16'h0000, d};
    @(posedge clk);
    while (wbAck !== 1'b1)
      @(posedge clk);
    q = wbDatR[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
  endtask

  // access of b+1 beats; the next setting is written while this one runs
  task automatic access(input logic wr, input logic [1:0] b, input logic [15:0] c,
                        input logic [15:0] nxt);
    int cw;
    int ce;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqRow <= 12'h0A5;
    reqCol <= 12'h3C0;
    reqBeats <= b;
    @(posedge clk);
    reqValid <= 1'b0;
    wbCycle(1'b1, 4'h0, nxt);
    while (accessDone !== 1'b1)
      @(posedge clk);
    // row strobe ends one cycle after the last column strobe unless its width is longer
    cw = 2 + (wr ? c[7:6] : c[9:8]);
    ce = ((c[3:2] == 2'b10) ? 4 : 3) + (b + 1) * cw + b * (1 + c[5]) + 1;
    check({8'h00, casDelayM}, 16'((c[3:2] == 2'b10) ? 4 : 3));
    check({8'h00, colDelayM}, 16'(1 + c[4]));
    if (b != 2'h0)
    begin
      check({8'h00, colHoldM}, 16'(1 + c[10]));
      check({8'h00, casPreM}, 16'(1 + c[5]));
    end
    check({8'h00, casW}, 16'(cw));
    check({15'h0000, weLow}, {15'h0000, wr});
    check({15'h0000, rasW >= 8'(4 + c[12:11])}, 16'h0001);
    check({8'h00, rasW}, 16'((4 + c[12:11] > ce) ? 4 + c[12:11] : ce));
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial
  begin
    rstn = 1'b0;
    {wbWe, wbCyc, wbStb, reqValid, reqWrite} = 5'h00;
    wbAdr = 4'h0;
    wbSel = 4'h0;
    wbDatW = 32'h0000_0000;
    reqRow = 12'h000;
    reqCol = 12'h000;
    reqBeats = 2'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wbCycle(1'b0, 4'h0, 16'h0000);
    check(q, 16'h1514);
    wbCycle(1'b1, 4'h0, 16'hFFFF);
    wbCycle(1'b0, 4'h0, 16'h0000);
    check(q, 16'h1FFC);
    wbCycle(1'b0, 4'h8, 16'h0000);
    check(q, 16'h0000);
    wbCycle(1'b1, 4'h0, cfg[0]);
    for (int i = 0; i < 5; i++)
    begin
      access(1'b0, 2'h1, cfg[i], cfg[i]);
      access(1'b1, 2'h1, cfg[i], cfg[(i + 1) % 5]);
    end
    // a single beat lets the row strobe width, not the column strobes, set the row period
    wbCycle(1'b1, 4'h0, cfg[4]);
    access(1'b0, 2'h0, cfg[4], cfg[0]);
    wbCycle(1'b0, 4'h4, 16'h0000);
    check(q, 16'h0B00);
    close_out();
  end
endmodule
